// ===== design/bcl_pkg.sv
// Summary of operation
// - Baud select pins read at bits 22:20
// - Baud code doubles rate, 300 up to 38400
// - Processor role bits 19:18 always read 00
// - Boot diag pins read at bits 17:16
// - Boot diag code selects power-up mode
// - Storage bus id jumpers read at 15:13
// - LED register holds four read/write bits
// - Stored zero lights LED, one turns off
// - Power-up, or power-ok loss unless inhibited, clears LEDs
// - LED bits 31:4 read zero
package bcl_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LED_W = 4;

    localparam logic [ADDR_W-1:0] DIAG_LED_CONTROL_ADDR = 32'h20140020;
    localparam logic [ADDR_W-1:0] BOOT_CONFIG_STATUS_ADDR = 32'h20084004;
    localparam logic [ADDR_W-1:0] SYSTEM_CONFIG_ADDR = 32'h20140030;

    localparam int BAUD_LSB = 20;
    localparam int ROLE_LSB = 18;
    localparam int BOOT_DIAG_LSB = 16;
    localparam int STORAGE_ID_LSB = 13;
    localparam int UNUSED_W = 12;
    localparam int SCR_LAMP_INHIBIT_BIT = 7;

    localparam logic [1:0] ROLE_ARBITER = 2'h0;
    localparam logic [LED_W-1:0] LED_RESET = 4'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0;

    typedef enum logic [1:0] {
        BCL_MODE_RUN = 2'h0,
        BCL_MODE_LANG_INQUIRY = 2'h1,
        BCL_MODE_TEST = 2'h2,
        BCL_MODE_MANUFACTURING = 2'h3
    } bcl_boot_mode_t;

    typedef struct packed {
        logic [2:0] baud_select_pins;
        bcl_boot_mode_t boot_diag_code;
        logic [2:0] storage_bus_id;
    } bcl_strap_t;
endpackage : bcl_pkg

// ===== design/bcl_regs.sv
module bcl_regs #(
    parameter int ADDR_WIDTH = bcl_pkg::ADDR_W,
    parameter int DATA_WIDTH = bcl_pkg::DATA_W,
    parameter int LED_WIDTH = bcl_pkg::LED_W,
    parameter int LANE_WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,

    input wire logic [bcl_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [bcl_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [bcl_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,

    input wire bcl_pkg::bcl_strap_t straps,
    input wire logic dc_power_ok,
    output logic [bcl_pkg::LED_W-1:0] led_display_bits_n
);
    import bcl_pkg::*;

    // Field widths follow from the bit positions of the config word
    localparam int ROLE_W = BAUD_LSB - ROLE_LSB;
    localparam int BOOT_DIAG_W = ROLE_LSB - BOOT_DIAG_LSB;
    localparam int STORAGE_ID_W = BOOT_DIAG_LSB - STORAGE_ID_LSB;
    localparam int BAUD_W = $bits(bcl_strap_t) - BOOT_DIAG_W - STORAGE_ID_W;
    localparam int CFG_TOP_W = DATA_WIDTH - BAUD_LSB - BAUD_W;
    localparam int GAP_W = STORAGE_ID_LSB - UNUSED_W;
    localparam int LED_PAD_W = DATA_WIDTH - LED_WIDTH;
    localparam int SCR_HIGH_W = DATA_WIDTH - SCR_LAMP_INHIBIT_BIT - 1;
    localparam int LANE_PAD_W = LANE_WIDTH - LED_WIDTH;

    // Register layout is fixed at the bus width
    if (DATA_WIDTH != DATA_W) begin : gen_bad_data_width
        $error("bcl_regs: DATA_WIDTH must equal the register width");
    end

    // Address compare needs the full byte address
    if (ADDR_WIDTH != ADDR_W) begin : gen_bad_addr_width
        $error("bcl_regs: ADDR_WIDTH must equal the bus address width");
    end

    // The display port is sized by the package
    if (LED_WIDTH != LED_W) begin : gen_bad_led_width
        $error("bcl_regs: LED_WIDTH must equal the display width");
    end

    // Byte enables select eight-bit lanes
    if (LANE_WIDTH != 8) begin : gen_bad_lane_width
        $error("bcl_regs: LANE_WIDTH must be 8");
    end

    // All display bits sit inside lane 0
    if (LED_WIDTH < 1 || LED_WIDTH >= LANE_WIDTH) begin : gen_bad_led_range
        $error("bcl_regs: LED_WIDTH must be from 1 to LANE_WIDTH-1");
    end

    // The inhibit bit is written through lane 0
    if (SCR_LAMP_INHIBIT_BIT >= LANE_WIDTH) begin : gen_bad_scr_bit
        $error("bcl_regs: lamp inhibit bit must lie in lane 0");
    end

    // Every config field needs at least one bit
    if (ROLE_W < 1 || BOOT_DIAG_W < 1 || STORAGE_ID_W < 1 || BAUD_W < 1) begin : gen_bad_fields
        $error("bcl_regs: config field positions out of order");
    end

    // Role constant must fill its field
    if ($bits(ROLE_ARBITER) != ROLE_W) begin : gen_bad_role_width
        $error("bcl_regs: role code width does not match its field");
    end

    // Boot mode type must fill its field
    if ($bits(bcl_boot_mode_t) != BOOT_DIAG_W) begin : gen_bad_diag_width
        $error("bcl_regs: boot mode width does not match its field");
    end

    // Zero filler above the baud field and below the storage id
    if (CFG_TOP_W < 1 || GAP_W < 1) begin : gen_bad_filler
        $error("bcl_regs: config filler fields must not be empty");
    end

    // Low filler of ones must exist
    if (UNUSED_W < 1) begin : gen_bad_unused
        $error("bcl_regs: unused field must not be empty");
    end

    // Zero filler above the inhibit bit must exist
    if (SCR_HIGH_W < 1) begin : gen_bad_scr_high
        $error("bcl_regs: lamp inhibit bit must lie below the top bit");
    end

    // Fields must tile the word exactly
    if (CFG_TOP_W + BAUD_W + ROLE_W + BOOT_DIAG_W + STORAGE_ID_W + GAP_W + UNUSED_W
        != DATA_WIDTH) begin : gen_bad_tiling
        $error("bcl_regs: config fields do not cover the word");
    end

    // Only the arbiter role can be reported
    if (ROLE_ARBITER != 2'h0) begin : gen_bad_role_value
        $error("bcl_regs: role code must read as zero");
    end

    // Reset pattern must match the display
    if ($bits(LED_RESET) != LED_WIDTH) begin : gen_bad_led_reset
        $error("bcl_regs: LED reset width does not match the display");
    end

    // Unmapped read value must match the bus
    if ($bits(UNMAPPED_READ) != DATA_WIDTH) begin : gen_bad_unmapped
        $error("bcl_regs: unmapped read width does not match the bus");
    end

    // Registers are decoded as whole words
    if (DIAG_LED_CONTROL_ADDR[1:0] != 2'h0) begin : gen_bad_led_align
        $error("bcl_regs: LED register address must be word aligned");
    end

    // Registers are decoded as whole words
    if (BOOT_CONFIG_STATUS_ADDR[1:0] != 2'h0) begin : gen_bad_cfg_align
        $error("bcl_regs: config register address must be word aligned");
    end

    // Registers are decoded as whole words
    if (SYSTEM_CONFIG_ADDR[1:0] != 2'h0) begin : gen_bad_scr_align
        $error("bcl_regs: system config address must be word aligned");
    end

    // Overlapping decodes would hide a register
    if (DIAG_LED_CONTROL_ADDR == BOOT_CONFIG_STATUS_ADDR) begin : gen_bad_led_cfg
        $error("bcl_regs: LED and config registers share an address");
    end

    // Overlapping decodes would hide a register
    if (DIAG_LED_CONTROL_ADDR == SYSTEM_CONFIG_ADDR) begin : gen_bad_led_scr
        $error("bcl_regs: LED and system config registers share an address");
    end

    // Overlapping decodes would hide a register
    if (BOOT_CONFIG_STATUS_ADDR == SYSTEM_CONFIG_ADDR) begin : gen_bad_cfg_scr
        $error("bcl_regs: config and system config registers share an address");
    end

    // Bus handshake: one wait cycle, then the answer cycle
    typedef enum {
        BCL_BUS_IDLE,
        BCL_BUS_ANSWER
    } bcl_bus_state_t;

    bcl_bus_state_t bus_state_r;
    bcl_bus_state_t bus_state_nxt;
    logic waitrequest_r;
    logic waitrequest_nxt;
    logic [DATA_WIDTH-1:0] readdata_r;
    logic [DATA_WIDTH-1:0] readdata_nxt;
    logic [LED_WIDTH-1:0] led_r;
    logic [LED_WIDTH-1:0] led_nxt;
    logic scr_r;
    logic scr_nxt;
    logic dc_power_ok_prev_r;
    logic [BAUD_W-1:0] baud_r;
    bcl_boot_mode_t boot_diag_r;
    logic [STORAGE_ID_W-1:0] storage_id_r;

    // Address compare shared by all register decodes
    function automatic logic reg_hit(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [ADDR_WIDTH-1:0] base
    );
        return addr == base;
    endfunction : reg_hit

    // A lane is replaced only when its byte enable is set
    function automatic logic [LANE_WIDTH-1:0] lane_merge(
        input logic [LANE_WIDTH-1:0] old_lane,
        input logic [LANE_WIDTH-1:0] new_lane,
        input logic lane_en
    );
        return lane_en ? new_lane : old_lane;
    endfunction : lane_merge

    // Baud code passes through; it doubles the rate from 300 to 38400
    function automatic logic [DATA_WIDTH-1:0] compose_cfg(
        input logic [BAUD_W-1:0] baud,
        input bcl_boot_mode_t diag,
        input logic [STORAGE_ID_W-1:0] id
    );
        return {
            {CFG_TOP_W{1'b0}},
            baud,
            ROLE_ARBITER,
            diag,
            id,
            {GAP_W{1'b0}},
            {UNUSED_W{1'b1}}
        };
    endfunction : compose_cfg

    // Request decode
    wire in_idle = bus_state_r == BCL_BUS_IDLE;
    wire in_answer = bus_state_r == BCL_BUS_ANSWER;
    wire req = read | write;
    wire take = req & in_idle;
    wire done = req & in_answer;
    wire wr_done = done & write;

    wire hit_led = reg_hit(address, DIAG_LED_CONTROL_ADDR);
    wire hit_cfg = reg_hit(address, BOOT_CONFIG_STATUS_ADDR);
    wire hit_scr = reg_hit(address, SYSTEM_CONFIG_ADDR);
    wire lane0_en = byteenable[0];
    wire [LANE_WIDTH-1:0] wr_lane = writedata[LANE_WIDTH-1:0];
    wire led_wr = wr_done & hit_led;
    wire scr_wr = wr_done & hit_scr;

    // Falling edge of power-ok clears the display unless inhibited
    wire dc_power_ok_fell = dc_power_ok_prev_r & ~dc_power_ok;
    wire lamp_test = dc_power_ok_fell & ~scr_r;

    wire [DATA_WIDTH-1:0] cfg_word = compose_cfg(baud_r, boot_diag_r, storage_id_r);
    wire [DATA_WIDTH-1:0] led_word = {
        {LED_PAD_W{1'b0}},
        led_r
    };
    wire [DATA_WIDTH-1:0] scr_word = {
        {SCR_HIGH_W{1'b0}},
        scr_r,
        {SCR_LAMP_INHIBIT_BIT{1'b0}}
    };
    // Unmapped addresses read as zero
    wire [DATA_WIDTH-1:0] rd_sel =
        hit_led ? led_word :
        hit_cfg ? cfg_word :
        hit_scr ? scr_word :
        UNMAPPED_READ;

    // Writes use lane 0 only; config writes reach no register
    wire [LANE_WIDTH-1:0] led_lane_old = {{LANE_PAD_W{1'b0}}, led_r};
    wire [LANE_WIDTH-1:0] led_lane_new = lane_merge(
        led_lane_old,
        wr_lane,
        led_wr & lane0_en
    );
    wire [LANE_WIDTH-1:0] scr_lane_old = {LANE_WIDTH{scr_r}};
    wire [LANE_WIDTH-1:0] scr_lane_new = lane_merge(
        scr_lane_old,
        wr_lane,
        scr_wr & lane0_en
    );

    // Lamp test wins over a write in the same cycle
    assign led_nxt = lamp_test ? LED_RESET : led_lane_new[LED_WIDTH-1:0];
    assign scr_nxt = scr_lane_new[SCR_LAMP_INHIBIT_BIT];
    assign readdata_nxt = take ? rd_sel : readdata_r;
    assign waitrequest_nxt = bus_state_nxt != BCL_BUS_ANSWER;

    // Every request gets exactly one wait cycle
    always_comb begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            BCL_BUS_IDLE: begin
                if (req) begin
                    bus_state_nxt = BCL_BUS_ANSWER;
                end
            end
            BCL_BUS_ANSWER: begin
                bus_state_nxt = BCL_BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BCL_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_state_r <= BCL_BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            waitrequest_r <= 1'b1;
        end else begin
            waitrequest_r <= waitrequest_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            readdata_r <= UNMAPPED_READ;
        end else begin
            readdata_r <= readdata_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scr_r <= 1'b0;
        end else begin
            scr_r <= scr_nxt;
        end
    end

    // Reset value high so release gives no false falling edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dc_power_ok_prev_r <= 1'b1;
        end else begin
            dc_power_ok_prev_r <= dc_power_ok;
        end
    end

    // Power-up lights every LED
    always_ff @(posedge core_clk) begin
        if (rst) begin
            led_r <= LED_RESET;
        end else begin
            led_r <= led_nxt;
        end
    end

    // Straps are sampled every cycle; writes never reach them
    always_ff @(posedge core_clk) begin
        baud_r <= straps.baud_select_pins;
    end

    always_ff @(posedge core_clk) begin
        boot_diag_r <= straps.boot_diag_code;
    end

    always_ff @(posedge core_clk) begin
        storage_id_r <= straps.storage_bus_id;
    end

    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    // Stored bit drives its pin directly, so a zero lights the LED
    assign led_display_bits_n = led_r;
endmodule : bcl_regs

// ===== verif/bcl_panel.sv
module bcl_panel import bcl_pkg::*; (input wire bcl_strap_t set, output bcl_strap_t straps);
    timeunit 1ns; timeprecision 1ns;
    assign straps = set;
endmodule : bcl_panel

// ===== verif/bcl_regs_monitor.sv
module bcl_monitor import bcl_pkg::*; (input wire logic core_clk, rst, read, write,
    input wire logic waitrequest, dc_power_ok, input wire logic [3:0] byteenable,
    input wire logic [3:0] led_display_bits_n, input wire logic [31:0] address, writedata, readdata);
    timeunit 1ns; timeprecision 1ns;
    logic inh_r;
    wire [3:0] led = led_display_bits_n;
    wire f = !waitrequest, c = read && f && address == BOOT_CONFIG_STATUS_ADDR;
    wire w = write && f && byteenable[0] && dc_power_ok, l = address == DIAG_LED_CONTROL_ADDR;
    always_ff @(posedge core_clk) if (rst) inh_r <= 1'b0;
    else if (write && f && byteenable[0] && address == SYSTEM_CONFIG_ADDR) inh_r <= writedata[7];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    role_zero_a: assert property (c |-> readdata[19:18] == 0) else $error("role");
    low_ones_a: assert property (c |-> &readdata[11:0]) else $error("low");
    led_top_a: assert property (read && f && l |-> readdata[31:4] == 0) else $error("top");
    led_store_a: assert property (w && l |=> led == $past(writedata[3:0])) else $error("st");
    cfg_fixed_a: assert property (w && address == BOOT_CONFIG_STATUS_ADDR |=> $stable(led))
        else $error("cfg");
    lamp_test_a: assert property ($fell(dc_power_ok) && !inh_r |=> led == 0) else $error("lamp");
    reset_lit_a: assert property (disable iff (1'b0) rst |=> led == 0) else $error("rst");
    one_wait_a: assert property ((read || write) && !f |=> f) else $error("wait");
    cover property (c);
    cover property (w && l);
    cover property ($fell(dc_power_ok));
endmodule : bcl_monitor
bind bcl_regs bcl_monitor mon (.*);

// ===== verif/boot_config_and_led_regs_tb.sv
module boot_config_and_led_regs_tb;
    timeunit 1ns; timeprecision 1ns;
    import bcl_pkg::*;
    logic core_clk = 0, rst = 1, read = 0, write = 0, dc_power_ok = 1, waitrequest;
    logic [3:0] byteenable = 4'hF, led_display_bits_n;
    logic [31:0] address = 0, writedata = 0, readdata;
    bcl_strap_t set = 0, straps;
    int failures = 0, checks_done = 0;
`define CK(a, b) checks_done++; if ((a) !== (b)) begin failures++; $display("unexpected %0t value mismatch", $time); end
    always #25 core_clk = ~core_clk;
    bcl_regs dut (.*);
    bcl_panel pnl (.*);
    task automatic acc(input logic w, input logic [31:0] a, d);
        @(posedge core_clk) {read, write, address, writedata} <= {!w, w, a, d};
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        {read, write} <= 2'h0;
    endtask : acc
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    initial begin
        #100000 failures++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 0;
        for (int i = 0; i < 8; i++) begin
            set <= {i[2:0], i[1:0], ~i[2:0]};
            acc(1, BOOT_CONFIG_STATUS_ADDR, 32'h0);
            acc(0, BOOT_CONFIG_STATUS_ADDR, 32'h0);
            `CK(readdata, {9'h0, i[2:0], 2'h0, i[1:0], ~i[2:0], 13'hFFF})
        end
        $display("cfg end");
        `CK(led_display_bits_n, LED_RESET)
        acc(1, DIAG_LED_CONTROL_ADDR, 32'h5);
        acc(0, DIAG_LED_CONTROL_ADDR, 32'h0);
        `CK(readdata, 32'h5)
        `CK(led_display_bits_n, 4'h5)
        acc(0, 32'h0, 32'h0);
        `CK(readdata, UNMAPPED_READ)
        dc_power_ok <= 0;
        repeat (3) @(posedge core_clk);
        `CK(led_display_bits_n, 4'h0)
        dc_power_ok <= 1;
        acc(1, SYSTEM_CONFIG_ADDR, 32'h80);
        acc(1, DIAG_LED_CONTROL_ADDR, 32'hF);
        dc_power_ok <= 0;
        repeat (3) @(posedge core_clk);
        `CK(led_display_bits_n, 4'hF)
        $display("led end");
        report_and_stop;
    end
endmodule : boot_config_and_led_regs_tb
